/* File: rtl/mcr_regs.vh */
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// Register indices (one 32-bit word per index)
`define MCR_ADDR_W 16
`define MCR_OFS_RESET_CTRL_IDX 16'h0003
`define MCR_OFS_CONFIG_ZERO_IDX 16'h0004
`define MCR_OFS_FEATURES_IDX 16'h0002

// Control header layout
`define MCR_HDR_DNC 31
`define MCR_HDR_WNR 29
`define MCR_HDR_MMS_HI 27
`define MCR_HDR_MMS_LO 24
`define MCR_HDR_ADDR_HI 23
`define MCR_HDR_ADDR_LO 8

// reset_control fields
`define MCR_RST_REINIT_BIT 0
`define MCR_RESET_CTRL_RST 32'h00000000

// config_zero fields
`define MCR_CFG_DONE_BIT 15
`define MCR_CFG_FCS_BIT 14
`define MCR_CFG_SELALIGN_BIT 13
`define MCR_CFG_ZALIGN_BIT 12
`define MCR_CFG_CPS_HI 2
`define MCR_CFG_CPS_LO 0
`define MCR_CFG_CPS_RST 3'h6

// supported_features fields and fixed value
`define MCR_FEAT_RETRY_BIT 4
`define MCR_FEAT_RETRY_VAL 1'h0
`define MCR_FEAT_MIN_PAYLOAD_CODE_VAL 3'h3
`define MCR_FEAT_VALUE 32'h000006C3

// Timing
`define MCR_CLK_NS 20
`define MCR_CS_MIN_NS 100
`define MCR_CS_CNT_W 4

`endif

/* File: rtl/mcr_sync.v */
`timescale 1ns/1ns

// Two-flop synchroniser for asynchronous pin levels
module mcr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] stable_ff;

  // First stage feeds only the second stage
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= RESET_VAL;
      stable_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule // mcr_sync

/* File: rtl/mcr_config_reset_regs.v */
`timescale 1ns/1ns
`include "mcr_regs.vh"

// Contract
// - Retry capability field reads 0; meaningful only with chunked protocol.
// - Capability bits [2:0] report N, minimum payload 2^N bytes, value 3.
// - Code 110=64, 101=32, 100=16, 011=8 bytes.
// - Writing 1 to reset bit 0 reinitialises device, PHY and all registers.
// - Software reset waits until chip select is released.
// - Reset request bit clears itself; software sees it write-only.
// - Configuration-done bit 15 is copied into every receive footer.
// - Configuration-done sets on written 1, ignores 0, holds until reset.
// - After any reset: config-done clear, reset-complete set, interrupt on.
// - Bit 14 set: last four octets of host frames checked as FCS.
// - Bit 13 set: frames start only in first chunk after select, offset 0.
// - Bit 13 clear: frames may start in any receive chunk.
// - Bit 12 set: frames start at first payload word, offset 0.
// - Bit 12 clear: frames may start at any payload word.
// - Alignment options act only with the chunked protocol selected.
// - Capability bit 4 tells whether sequence checking and retry exist.
module mcr_config_reset_regs #(
  parameter OFS_W = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  input wire oa_protocol_sel,
  input wire rx_word_valid,
  input wire rx_chunk_first,
  input wire rx_frame_waiting,
  input wire reset_complete_clear,
  output wire irq_n,
  output wire reset_complete_flag,
  output wire device_reinit,
  output wire footer_config_done,
  output wire rx_frame_start,
  output wire [OFS_W-1:0] start_word_offset,
  output wire host_fcs_check_enable,
  output wire select_aligned_rx_enable,
  output wire payload_aligned_rx_enable,
  output wire [2:0] chunk_payload_size_field,
  output wire [2:0] min_payload_code,
  output wire chunk_retry_capable,
  output wire [7:0] min_payload_bytes
);

  // Least chip-select low time, rounded up to whole clocks
  localparam integer CS_MIN_CYC =
    (`MCR_CS_MIN_NS + `MCR_CLK_NS - 1) / `MCR_CLK_NS;
  localparam [`MCR_CS_CNT_W-1:0] CS_MIN_CNT =
    CS_MIN_CYC[`MCR_CS_CNT_W-1:0];

  // Serial command states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_HDR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire oa_sel_s;
  reg sclk_d_ff;
  reg cs_n_d_ff;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_assert;
  wire cs_release;
  wire cs_act;

  reg [3:0] state_ff;
  reg [4:0] bit_cnt_ff;
  reg [31:0] shift_in_ff;
  reg [31:0] shift_out_ff;
  reg [31:0] hdr_ff;
  reg miso_ff;
  reg wr_pulse_ff;
  reg [31:0] wr_data_ff;
  reg [`MCR_ADDR_W-1:0] wr_addr_ff;
  wire [31:0] hdr_next;
  wire [31:0] rd_value;

  reg reinit_pending_ff;
  reg [`MCR_CS_CNT_W-1:0] cs_low_cnt_ff;
  reg soft_rst_ff;
  reg reset_complete_ff;

  reg config_done_ff;
  reg fcs_check_ff;
  reg sel_align_ff;
  reg zero_align_ff;
  reg [2:0] cps_ff;
  wire [31:0] config_zero_rd;

  reg [OFS_W-1:0] word_idx_ff;
  reg armed_ff;
  reg first_chunk_ff;
  reg [OFS_W-1:0] swo_ff;
  wire [OFS_W-1:0] cur_idx;
  wire in_first_chunk;
  wire sel_ok;
  wire zero_ok;

  // Pin levels: clock, select (idle high), data and protocol strap
  mcr_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h2)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({oa_protocol_sel, spi_mosi, spi_cs_n, spi_sclk}),
    .sync_out({oa_sel_s, mosi_s, cs_n_s, sclk_s})
  );

  // Edge detection works on the settled copies only
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign cs_assert = ~cs_n_s & cs_n_d_ff;
  assign cs_release = cs_n_s & ~cs_n_d_ff;
  assign cs_act = ~cs_n_s;

  // Header as it stands once its last bit is shifted in
  assign hdr_next = {shift_in_ff[30:0], mosi_s};

  // Read view of config_zero; unlisted bits read zero
  assign config_zero_rd = {16'h0000, config_done_ff, fcs_check_ff,
                           sel_align_ff, zero_align_ff, 9'h000, cps_ff};

  // Read mux; reset_control is write-only and reads zero
  // request hidden
  function [31:0] read_mux;
    input [31:0] hdr;
    input [31:0] cfg;
    begin
      read_mux = 32'h00000000;
      // Data commands and other maps read zero
      if (!hdr[`MCR_HDR_DNC] &&
          hdr[`MCR_HDR_MMS_HI:`MCR_HDR_MMS_LO] == 4'h0) begin
        case (hdr[`MCR_HDR_ADDR_HI:`MCR_HDR_ADDR_LO])
          `MCR_OFS_FEATURES_IDX: read_mux = `MCR_FEAT_VALUE;
          `MCR_OFS_CONFIG_ZERO_IDX: read_mux = cfg;
          default: read_mux = 32'h00000000;
        endcase
      end
    end
  endfunction

  assign rd_value = read_mux(hdr_next, config_zero_rd);

  // Control command engine: 32 header bits then 32 data bits.
  // Sampling on the system clock limits the link clock to well below
  // a quarter of the system rate; the bench runs it at one eighth.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_in_ff <= 32'h00000000;
      shift_out_ff <= 32'h00000000;
      hdr_ff <= 32'h00000000;
      miso_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_data_ff <= 32'h00000000;
      wr_addr_ff <= 16'h0000;
    end else if (soft_rst_ff) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_in_ff <= 32'h00000000;
      shift_out_ff <= 32'h00000000;
      hdr_ff <= 32'h00000000;
      miso_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_data_ff <= 32'h00000000;
      wr_addr_ff <= 16'h0000;
    end else begin
      wr_pulse_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          miso_ff <= 1'b0;
          bit_cnt_ff <= 5'h00;
          if (cs_act) begin
            state_ff <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (!cs_act) begin
            state_ff <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_in_ff <= hdr_next;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == 5'h1F) begin
              hdr_ff <= hdr_next;
              shift_out_ff <= rd_value;
              state_ff <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (!cs_act) begin
            state_ff <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_in_ff <= hdr_next;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == 5'h1F) begin
              state_ff <= ST_DONE;
              wr_data_ff <= hdr_next;
              wr_addr_ff <= hdr_ff[`MCR_HDR_ADDR_HI:`MCR_HDR_ADDR_LO];
              // Data commands and other memory maps are not ours
              wr_pulse_ff <= hdr_ff[`MCR_HDR_WNR] &
                             ~hdr_ff[`MCR_HDR_DNC] &
                             (hdr_ff[`MCR_HDR_MMS_HI:`MCR_HDR_MMS_LO]
                              == 4'h0);
            end
          end else if (sclk_fall) begin
            miso_ff <= shift_out_ff[31];
            shift_out_ff <= {shift_out_ff[30:0], 1'b0};
          end
        end
        ST_DONE: begin
          // Extra clocks are ignored until select is released
          if (!cs_act) begin
            state_ff <= ST_IDLE;
          end else if (sclk_fall) begin
            miso_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration fields; hardware holds no setter but the host
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_done_ff <= 1'b0;
      fcs_check_ff <= 1'b0;
      sel_align_ff <= 1'b0;
      zero_align_ff <= 1'b0;
      cps_ff <= `MCR_CFG_CPS_RST;
    end else if (soft_rst_ff) begin
      config_done_ff <= 1'b0;
      fcs_check_ff <= 1'b0;
      sel_align_ff <= 1'b0;
      zero_align_ff <= 1'b0;
      cps_ff <= `MCR_CFG_CPS_RST;
    end else if (wr_pulse_ff &&
                 wr_addr_ff == `MCR_OFS_CONFIG_ZERO_IDX) begin
      config_done_ff <= config_done_ff | wr_data_ff[`MCR_CFG_DONE_BIT];
      fcs_check_ff <= wr_data_ff[`MCR_CFG_FCS_BIT];
      sel_align_ff <= wr_data_ff[`MCR_CFG_SELALIGN_BIT];
      zero_align_ff <= wr_data_ff[`MCR_CFG_ZALIGN_BIT];
      // The size is stored as written; staying above the minimum is
      // left to the host
      // host keeps size
      cps_ff <= wr_data_ff[`MCR_CFG_CPS_HI:`MCR_CFG_CPS_LO];
    end
  end

  // Deferred software reset: request, select timing, release
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reinit_pending_ff <= 1'b0;
      cs_low_cnt_ff <= {`MCR_CS_CNT_W{1'b0}};
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= 1'b0;
      if (!cs_act) begin
        cs_low_cnt_ff <= {`MCR_CS_CNT_W{1'b0}};
      end else if (cs_low_cnt_ff != CS_MIN_CNT) begin
        cs_low_cnt_ff <= cs_low_cnt_ff + {{(`MCR_CS_CNT_W-1){1'b0}}, 1'b1};
      end
      if (cs_release) begin
        soft_rst_ff <= reinit_pending_ff & (cs_low_cnt_ff == CS_MIN_CNT);
        reinit_pending_ff <= 1'b0;
      end else if (wr_pulse_ff &&
                   wr_addr_ff == `MCR_OFS_RESET_CTRL_IDX &&
                   wr_data_ff[`MCR_RST_REINIT_BIT]) begin
        reinit_pending_ff <= 1'b1;
      end
    end
  end

  // Reset-complete status; a new reset wins over a clear
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_complete_ff <= 1'b1;
    end else if (soft_rst_ff) begin
      reset_complete_ff <= 1'b1;
    end else if (reset_complete_clear) begin
      reset_complete_ff <= 1'b0;
    end
  end

  // Word position inside the current receive chunk payload
  assign cur_idx = rx_chunk_first ? {OFS_W{1'b0}} : word_idx_ff;
  assign in_first_chunk = rx_chunk_first ? armed_ff : first_chunk_ff;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_idx_ff <= {OFS_W{1'b0}};
      armed_ff <= 1'b0;
      first_chunk_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      word_idx_ff <= {OFS_W{1'b0}};
      armed_ff <= 1'b0;
      first_chunk_ff <= 1'b0;
    end else begin
      if (rx_word_valid) begin
        word_idx_ff <= cur_idx + {{(OFS_W-1){1'b0}}, 1'b1};
      end
      // Select assertion arms the next chunk as the first one
      if (cs_assert) begin
        armed_ff <= 1'b1;
        first_chunk_ff <= 1'b0;
      end else if (rx_word_valid && rx_chunk_first) begin
        first_chunk_ff <= armed_ff;
        armed_ff <= 1'b0;
      end
    end
  end

  // Frame start qualification; generic protocol ignores both options
  // first chunk only
  assign sel_ok = ~oa_sel_s | ~sel_align_ff |
                  (in_first_chunk & (cur_idx == {OFS_W{1'b0}}));
  assign zero_ok = ~oa_sel_s | ~zero_align_ff |
                   (cur_idx == {OFS_W{1'b0}});
  assign rx_frame_start = rx_word_valid & rx_frame_waiting & sel_ok &
                          zero_ok;

  // Offset held for the footer of the chunk that starts the frame
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      swo_ff <= {OFS_W{1'b0}};
    end else if (soft_rst_ff) begin
      swo_ff <= {OFS_W{1'b0}};
    end else if (rx_frame_start) begin
      swo_ff <= cur_idx;
    end
  end

  // Link side outputs
  assign spi_miso = miso_ff;
  assign spi_miso_oe = cs_act;

  assign irq_n = ~reset_complete_ff;
  assign reset_complete_flag = reset_complete_ff;
  assign device_reinit = soft_rst_ff;

  assign footer_config_done = config_done_ff;
  assign start_word_offset = swo_ff;

  assign host_fcs_check_enable = fcs_check_ff;
  assign select_aligned_rx_enable = sel_align_ff;
  assign payload_aligned_rx_enable = zero_align_ff;
  assign chunk_payload_size_field = cps_ff;

  assign chunk_retry_capable = `MCR_FEAT_RETRY_VAL;
  assign min_payload_code = `MCR_FEAT_MIN_PAYLOAD_CODE_VAL;
  assign min_payload_bytes = 8'h01 << min_payload_code;

endmodule // mcr_config_reset_regs

/* File: tb/mcr_config_reset_regs_monitor.sv */
`timescale 1ns/1ns
// Pin-level checks of the register bank, one clock domain
module mcr_config_reset_regs_monitor #(
  parameter OFS_W = 4
) (
  input wire sys_clk,
  input wire reset_n,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire oa_protocol_sel,
  input wire rx_word_valid,
  input wire rx_chunk_first,
  input wire rx_frame_waiting,
  input wire irq_n,
  input wire reset_complete_flag,
  input wire device_reinit,
  input wire footer_config_done,
  input wire rx_frame_start,
  input wire [OFS_W-1:0] start_word_offset,
  input wire host_fcs_check_enable,
  input wire select_aligned_rx_enable,
  input wire payload_aligned_rx_enable,
  input wire [2:0] chunk_payload_size_field,
  input wire [2:0] min_payload_code,
  input wire chunk_retry_capable,
  input wire [7:0] min_payload_bytes
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Reinit is a single pulse, then every field is back at default
  sequence reinit_pulse;
    device_reinit ##1 !device_reinit;
  endsequence
  sequence regs_default;
    reset_complete_flag && !irq_n && !footer_config_done &&
    chunk_payload_size_field == 3'h6 && start_word_offset == '0 &&
    !host_fcs_check_enable && !select_aligned_rx_enable &&
    !payload_aligned_rx_enable;
  endsequence
  AST_REINIT_SELF_CLEAR: assert property (device_reinit |-> reinit_pulse)
    else $error("reinit pulse longer than one cycle");
  AST_REINIT_DEFAULTS: assert property (device_reinit |=> regs_default)
    else $error("fields not at default after reinit");
  AST_REINIT_AFTER_CS: assert property (device_reinit |-> $past(spi_cs_n, 2))
    else $error("reinit while select still asserted");
  AST_IRQ_FOLLOWS: assert property (irq_n == !reset_complete_flag)
    else $error("interrupt pin disagrees with flag");
  AST_RETRY_ZERO: assert property (chunk_retry_capable == 1'b0)
    else $error("retry capability not zero");
  AST_MIN_CODE: assert property (min_payload_code == 3'h3 && min_payload_bytes == 8'h08)
    else $error("minimum payload report wrong");
  AST_DONE_STICKY: assert property ($fell(footer_config_done) |-> $past(device_reinit))
    else $error("config done cleared without reset");
  AST_START_CAUSE: assert property (rx_frame_start |-> rx_word_valid && rx_frame_waiting)
    else $error("frame start without waiting word");
  AST_ZERO_ALIGN: assert property (rx_frame_start && payload_aligned_rx_enable && oa_protocol_sel && $past(oa_protocol_sel, 3) |-> rx_chunk_first ##1 start_word_offset == '0)
    else $error("aligned start off word zero");
  AST_SEL_ALIGN: assert property (rx_frame_start && select_aligned_rx_enable && oa_protocol_sel && $past(oa_protocol_sel, 3) |-> rx_chunk_first ##1 start_word_offset == '0)
    else $error("select aligned start off chunk start");
  AST_MISO_OE: assert property (spi_miso_oe |-> !$past(spi_cs_n, 2))
    else $error("data pin driven while deselected");
endmodule // mcr_config_reset_regs_monitor

bind mcr_config_reset_regs mcr_config_reset_regs_monitor #(.OFS_W(OFS_W)) mon_i (.*);

/* File: tb/mcr_spi_host.sv */
`timescale 1ns/1ns
// Host side of the register link, mode 0, clock idle low
module mcr_spi_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire spi_miso
);
  localparam int HALF = 80;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One frame; fewer than 64 bits aborts it
  // select low far beyond 100 ns
  task automatic xfer(input logic [31:0] hdr, input logic [31:0] wd,
                      input int nbits, output logic [31:0] rd);
    logic [63:0] sh;
    sh = {hdr, wd};
    rd = 32'h0;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = sh[63-i];
      #HALF spi_sclk = 1'b1;
      if (i >= 32) rd = {rd[30:0], spi_miso};
      #HALF spi_sclk = 1'b0;
    end
    #HALF spi_cs_n = 1'b1;
    // Released line flips so a stale level cannot pass
    spi_mosi = ~spi_mosi;
    #(2 * HALF);
  endtask
endmodule // mcr_spi_host

/* File: tb/mcr_config_reset_regs_tb.sv */
`timescale 1ns/1ns
// Bench for the configuration and reset register bank
module mcr_config_reset_regs_tb;
  localparam int DLY = 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic oa_protocol_sel = 1'b1;
  logic rx_word_valid = 1'b0;
  logic rx_chunk_first = 1'b0;
  logic rx_frame_waiting = 1'b0;
  logic reset_complete_clear = 1'b0;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire irq_n, reset_complete_flag, device_reinit, footer_config_done;
  wire rx_frame_start, host_fcs_check_enable, chunk_retry_capable;
  wire select_aligned_rx_enable, payload_aligned_rx_enable;
  wire [3:0] start_word_offset;
  wire [2:0] chunk_payload_size_field, min_payload_code;
  wire [7:0] min_payload_bytes;
  int fails = 0;
  int num_checks = 0;
  int idx = 0;
  int reinits = 0;
  logic [3:0] swo_m = 4'h0;
  logic [15:0] cfg_m = 16'h0006;
  logic armed = 1'b0;
  logic [31:0] w;

  mcr_config_reset_regs #(.OFS_W(4)) mcr_config_reset_regs_i (.*);
  mcr_spi_host mcr_spi_host_i (.*);

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Count reinit pulses; each must land while select is released
  always @(posedge sys_clk) begin
    if (device_reinit === 1'b1) begin
      reinits++;
      check(32'(spi_cs_n), 32'h1); // after release
    end
  end

  function automatic logic [31:0] hdr(input logic wr, input logic [15:0] ix);
    return {2'b00, wr, 5'h00, ix, 8'h00};
  endfunction

  function automatic logic [31:0] cfg_exp(input logic [15:0] m);
    return {16'h0000, m[15:12], 9'h000, m[2:0]};
  endfunction

  // Frame start decision from the alignment options
  function automatic logic start_exp(input logic first, input logic wt);
    if (!wt) return 1'b0;
    if (!oa_protocol_sel) return 1'b1;
    if (cfg_m[13]) return first && armed;
    if (cfg_m[12]) return first;
    return 1'b1;
  endfunction

  task automatic wr_reg(input logic [15:0] ix, input logic [31:0] d, input int n);
    logic [31:0] r;
    mcr_spi_host_i.xfer(hdr(1'b1, ix), d, n, r);
  endtask

  task automatic rd_chk(input logic [15:0] ix, input logic [31:0] exp);
    logic [31:0] r;
    mcr_spi_host_i.xfer(hdr(1'b0, ix), 32'h0, 64, r);
    check(r, exp);
  endtask

  task automatic cfg_ports;
    check(32'({footer_config_done, host_fcs_check_enable,
      select_aligned_rx_enable, payload_aligned_rx_enable,
      chunk_payload_size_field}), 32'({cfg_m[15:12], cfg_m[2:0]})); // outputs
  endtask

  task automatic wr_cfg(input logic [31:0] d);
    wr_reg(16'h0004, d, 64);
    cfg_m = {cfg_m[15] | d[15], d[14:12], 9'h000, d[2:0]};
    rd_chk(16'h0004, cfg_exp(cfg_m)); // readback
    cfg_ports;
    armed = 1'b1;
  endtask

  task automatic rx_word(input logic first, input logic wt);
    logic s;
    idx = first ? 0 : idx + 1;
    s = start_exp(first, wt);
    if (s) swo_m = 4'(idx);
    if (first) armed = 1'b0;
    @(posedge sys_clk) #DLY;
    rx_word_valid = 1'b1;
    rx_chunk_first = first;
    rx_frame_waiting = wt;
    #5 check(32'(rx_frame_start), 32'(s)); // start
    @(posedge sys_clk) #DLY;
    rx_word_valid = 1'b0;
    check(32'(start_word_offset), 32'(swo_m)); // reported offset
  endtask

  initial begin
    void'($urandom(83461));
    repeat (20) @(posedge sys_clk);
    #DLY reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #DLY;
    check(32'({irq_n, reset_complete_flag, footer_config_done}), 32'h2); // power-up
    cfg_ports;
    rd_chk(16'h0002, 32'h000006C3); // capability
    check(32'({chunk_retry_capable, min_payload_code, min_payload_bytes}), 32'h308); // code
    rd_chk(16'h0003, 32'h0); // write-only
    rd_chk(16'h0005, 32'h0);
    reset_complete_clear = 1'b1;
    @(posedge sys_clk) #DLY reset_complete_clear = 1'b0;
    check(32'({irq_n, reset_complete_flag}), 32'h2); // flag cleared
    // code kept at or above minimum
    for (int k = 0; k < 6; k++) begin
      w = $urandom;
      w[2:0] = 3'(3 + $urandom_range(3));
      if (k == 2) w[15] = 1'b1;
      wr_cfg(w);
    end
    wr_cfg(32'h0000_0003);
    // Aborted frame must not write
    wr_reg(16'h0004, ~w, 40);
    rd_chk(16'h0004, cfg_exp(cfg_m)); // unchanged
    for (int m = 0; m < 4; m++) begin
      oa_protocol_sel = (m != 3);
      wr_cfg({18'h0, m == 2, m[0], 9'h000, 3'h3});
      rx_word(1'b1, 1'b1);
      rx_word(1'b1, 1'b1);
      for (int j = 0; j < 14; j++) rx_word($urandom_range(3) == 0, 1'($urandom));
    end
    wr_cfg(32'h0000_F005);
    reinits = 0;
    wr_reg(16'h0003, 32'h1, 64);
    repeat (4) @(posedge sys_clk);
    #DLY;
    check(32'(reinits), 32'h1); // single pulse
    cfg_m = 16'h0006;
    cfg_ports;
    check(32'({irq_n, reset_complete_flag}), 32'h1); // flags set
    rd_chk(16'h0003, 32'h0); // self clearing
    rd_chk(16'h0004, 32'h6); // defaults back
    wr_reg(16'h0003, 32'h0, 64);
    check(32'(reinits), 32'h1); // zero ignored
    report_and_stop;
  end

  // Cut a hang short; about three times the expected run
  initial begin
    #1000000;
    fails++;
    report_and_stop;
  end
endmodule // mcr_config_reset_regs_tb
